// ==== shared/ris_defines.vh ====
`ifndef RIS_DEFINES_VH
`define RIS_DEFINES_VH

// ----------------------------------------
// Boot record layout
// ----------------------------------------
`define RIS_BOOT_BASE   32'hFFFF_FF00
`define RIS_BOOT_WORDS  4'h8
`define RIS_BOOT_PROCESS_CONTROL_BLOCK   4'h1
`define RIS_BOOT_IP     4'h3
`define RIS_CHK_CONST   32'hFFFF_FFFF

// ----------------------------------------
// Control block layout
// ----------------------------------------
`define RIS_PROCESS_CONTROL_BLOCK_WORDS  4'h5
`define RIS_PROCESS_CONTROL_BLOCK_CFG    4'h4
`define RIS_NUM_PTRS    4

// ----------------------------------------
// Pin levels in reset and hold; fail level in reset only
// ----------------------------------------
`define RIS_ALE_IDLE    1'h0
`define RIS_ADS_IDLE    1'h1
`define RIS_BE_IDLE     4'hF
`define RIS_WR_IDLE     1'h0
`define RIS_DTR_IDLE    1'h0
`define RIS_DEN_IDLE    1'h1
`define RIS_BURST_LAST_IDLE  1'h1
`define RIS_FAIL_RESET  1'h0

`endif

// ==== hw/ris_sync.v ====
`timescale 1ns/1ps
module ris_sync
(
  input  wire       i_sys_clk,
  input  wire       i_rst,
  input  wire       i_reset_n,
  input  wire [1:0] i_lvl,
  output wire       o_in_reset,
  output wire [1:0] o_lvl
);
  reg [1:0] rchain;
  reg [1:0] s1;
  reg [1:0] s2;

  // Assert at once, release after two clean edges
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rchain <= 2'h0;
    else if (i_rst)
      rchain <= 2'h0;
    else
      rchain <= {rchain[0], 1'b1};
  end

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      s1 <= 2'h0;
      s2 <= 2'h0;
    end
    else
    begin
      s1 <= i_lvl;
      s2 <= s1;
    end
  end

  assign o_in_reset = ~rchain[1];
  assign o_lvl      = s2;
endmodule // ris_sync

// ==== hw/ris_word_reader.v ====
`timescale 1ns/1ps
module ris_word_reader
(
  input  wire        i_sys_clk,
  input  wire        i_rst_a,
  input  wire        i_start,
  input  wire [31:0] i_base,
  input  wire [3:0]  i_count,
  input  wire        i_stall,
  output reg         o_mem_req,
  output reg  [31:0] o_mem_addr,
  input  wire        i_mem_ack,
  input  wire [31:0] i_mem_data,
  output reg         o_word_vld,
  output reg  [3:0]  o_word_idx,
  output reg  [31:0] o_word,
  output reg         o_done
);
  reg [3:0] idx;
  reg [3:0] cnt;
  reg       busy;

  always @(posedge i_sys_clk or posedge i_rst_a)
  begin
    if (i_rst_a)
    begin
      o_mem_req  <= 1'b0;
      o_mem_addr <= 32'h0;
      o_word_vld <= 1'b0;
      o_word_idx <= 4'h0;
      o_word     <= 32'h0;
      o_done     <= 1'b0;
      idx        <= 4'h0;
      cnt        <= 4'h0;
      busy       <= 1'b0;
    end
    else
    begin
      o_word_vld <= 1'b0;
      o_done     <= 1'b0;
      if (i_start)
      begin
        busy       <= 1'b1;
        idx        <= 4'h0;
        cnt        <= i_count;
        o_mem_addr <= i_base;
        o_mem_req  <= 1'b0;
      end
      else if (busy && o_mem_req && i_mem_ack)
      begin
        o_mem_req  <= 1'b0;
        o_word_vld <= 1'b1;
        o_word_idx <= idx;
        o_word     <= i_mem_data;
        o_mem_addr <= o_mem_addr + 32'h4;
        idx        <= idx + 4'h1;
        if ((idx + 4'h1) == cnt)
        begin
          busy   <= 1'b0;
          o_done <= 1'b1;
        end
      end
      // New reads wait while the bus is lent out
      else if (busy && !o_mem_req && !i_stall)
        o_mem_req <= 1'b1;
    end
  end
endmodule // ris_word_reader

// ==== hw/ris_reset_init_seq.v ====
`timescale 1ns/1ps
`include "ris_defines.vh"

// Behaviour
// RL1: Quiescent, pins inactive, state forced in reset
// RL2: Initialization starts only after reset release
// RL3: Read boot record for IP and PROCESS_CONTROL_BLOCK
// RL4: Configure from control block information
// RL5: Cache system structure pointers internally
// RL6: Software re-init with new PROCESS_CONTROL_BLOCK and IP
// RL7: Run bus confidence and internal self tests
// RL8: Self-test select decides built-in self test
// RL9: Branch to first user instruction when done
// RL10: Reset input level-sensitive and asynchronous
// RL11: Grant bus hold while in reset
// RL12: Keep hold grant until request drops
// RL13: System holds warm reset minimum cycles
// RL14: System holds cold reset until clock stable
// RL15: Only the reset pin enters reset
// RL16: Reset sets internal registers to defined values
// RL17: Float bus, low address, status; ALE low
// RL18: Strobes high, direction low, fail low
// RL19: Self-test select sampled at reset rising edge
// RL20: Reset release synchronised to clock
module ris_reset_init_seq
(
  input  wire         i_sys_clk,
  input  wire         i_rst,
  input  wire         i_reset_n,
  input  wire         i_self_test_select,
  input  wire         i_bus_hold_req,
  input  wire         i_core_hold_ok,
  input  wire         i_reinit,
  input  wire [31:0]  i_reinit_process_control_block,
  input  wire [31:0]  i_reinit_ip,
  output wire         o_mem_req,
  output wire [31:0]  o_mem_addr,
  input  wire         i_mem_ack,
  input  wire [31:0]  i_mem_data,
  output reg          o_bist_start,
  input  wire         i_bist_done,
  input  wire         i_bist_pass,
  input  wire [31:0]  i_core_ad,
  input  wire         i_core_ad_oe,
  input  wire         i_core_ale,
  input  wire         i_core_ads_n,
  input  wire [1:0]   i_core_low_addr,
  input  wire         i_core_low_addr_oe,
  input  wire [3:0]   i_core_be_n,
  input  wire [1:0]   i_core_whs,
  input  wire         i_core_whs_oe,
  input  wire         i_core_dc,
  input  wire         i_core_dc_oe,
  input  wire         i_core_wr,
  input  wire         i_core_dtr,
  input  wire         i_core_den_n,
  input  wire         i_core_burst_last_n,
  output reg  [31:0]  o_addr_data_bus,
  output reg          o_addr_data_bus_oe,
  output reg          o_addr_latch,
  output reg          o_address_strobe_n,
  output reg  [1:0]   o_low_address_bits,
  output reg          o_low_address_bits_oe,
  output reg  [3:0]   o_byte_lane_selects_n,
  output reg  [1:0]   o_width_halt_status,
  output reg          o_width_halt_status_oe,
  output reg          o_data_code_status,
  output reg          o_data_code_status_oe,
  output reg          o_write_read,
  output reg          o_transceiver_direction,
  output reg          o_data_enable_strobe_n,
  output reg          o_burst_last_n,
  output reg          o_bus_hold_grant,
  output reg          o_fail_n,
  output wire         o_in_reset,
  output wire         o_init_busy,
  output reg          o_branch,
  output reg  [31:0]  o_branch_ip,
  output reg  [31:0]  o_process_control_block_addr,
  output reg  [31:0]  o_config,
  output wire [127:0] o_sys_ptrs
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] S_RESET  = 3'h0;
  localparam [2:0] S_BIST   = 3'h1;
  localparam [2:0] S_BOOT   = 3'h2;
  localparam [2:0] S_CHECK  = 3'h3;
  localparam [2:0] S_PROCESS_CONTROL_BLOCK   = 3'h4;
  localparam [2:0] S_BRANCH = 3'h5;
  localparam [2:0] S_RUN    = 3'h6;
  localparam [2:0] S_FAIL   = 3'h7;

  wire        rst_a;
  wire [1:0]  lvl_s;
  wire        hold_s;
  wire        self_test_select_s;
  wire        wvld;
  wire [3:0]  widx;
  wire [31:0] word;
  wire        rd_done;
  wire [31:0] chk;
  reg  [2:0]  state;
  reg         bist_sel;
  reg         rd_start;
  reg  [31:0] rd_base;
  reg  [3:0]  rd_cnt;
  reg  [31:0] sum;
  reg  [31:0] boot_ip;

  reg  [31:0] next_ad;
  reg         next_ad_oe;
  reg         next_ale;
  reg         next_ads_n;
  reg  [1:0]  next_low;
  reg         next_low_oe;
  reg  [3:0]  next_be_n;
  reg  [1:0]  next_whs;
  reg         next_whs_oe;
  reg         next_dc;
  reg         next_dc_oe;
  reg         next_wr;
  reg         next_dtr;
  reg         next_den_n;
  reg         next_burst_last_n;

  function word_hit;
    input       vld;
    input [3:0] idx;
    input [3:0] k;
    begin
      word_hit = vld && (idx == k);
    end
  endfunction

  // ----------------------------------------
  // Reset and input synchronisers
  // ----------------------------------------
  // Reset asserts at once, releases on the clock
  ris_sync u_sync // [RL10] [RL20]
  (
    .i_sys_clk  (i_sys_clk),
    .i_rst      (i_rst),
    .i_reset_n  (i_reset_n),
    .i_lvl      ({i_self_test_select, i_bus_hold_req}),
    .o_in_reset (rst_a),
    .o_lvl      (lvl_s)
  );

  assign hold_s     = lvl_s[0];
  assign self_test_select_s    = lvl_s[1];
  assign o_in_reset = rst_a; // [RL15]

  // ----------------------------------------
  // Boot record and control block reads
  // ----------------------------------------
  ris_word_reader u_reader
  (
    .i_sys_clk  (i_sys_clk),
    .i_rst_a    (rst_a),
    .i_start    (rd_start),
    .i_base     (rd_base),
    .i_count    (rd_cnt),
    .i_stall    (o_bus_hold_grant),
    .o_mem_req  (o_mem_req),
    .o_mem_addr (o_mem_addr),
    .i_mem_ack  (i_mem_ack),
    .i_mem_data (i_mem_data),
    .o_word_vld (wvld),
    .o_word_idx (widx),
    .o_word     (word),
    .o_done     (rd_done)
  );

  // ----------------------------------------
  // Self-test select capture
  // ----------------------------------------
  // Last level seen while in reset is the one at release
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      bist_sel <= 1'b0;
    else if (rst_a)
      bist_sel <= self_test_select_s; // [RL19] [RL8]
  end

  // ----------------------------------------
  // Bus hold grant
  // ----------------------------------------
  // Not cleared by the reset pin, so a hold in
  // progress survives a warm reset
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_bus_hold_grant <= 1'b0;
    else if (rst_a)
      o_bus_hold_grant <= hold_s; // [RL11]
    else if (o_bus_hold_grant)
      o_bus_hold_grant <= hold_s; // [RL12]
    else
      o_bus_hold_grant <= hold_s & i_core_hold_ok;
  end

  // ----------------------------------------
  // Initialization sequencer
  // ----------------------------------------
  assign chk         = sum + `RIS_CHK_CONST;
  assign o_init_busy = (state != S_RUN) && (state != S_FAIL);

  always @(posedge i_sys_clk or posedge rst_a)
  begin
    if (rst_a)
    begin
      state        <= S_RESET; // [RL1] [RL16]
      o_fail_n     <= `RIS_FAIL_RESET;
      o_bist_start <= 1'b0;
      rd_start     <= 1'b0;
      rd_base      <= 32'h0;
      rd_cnt       <= 4'h0;
      sum          <= 32'h0;
      boot_ip      <= 32'h0;
      o_process_control_block_addr  <= 32'h0;
      o_config     <= 32'h0;
      o_branch     <= 1'b0;
      o_branch_ip  <= 32'h0;
    end
    else
    begin
      o_bist_start <= 1'b0;
      rd_start     <= 1'b0;
      o_branch     <= 1'b0;
      case (state)
        S_RESET:
        begin
          // First cycle after release
          sum <= 32'h0;
          if (bist_sel)
          begin
            o_bist_start <= 1'b1; // [RL2] [RL7] [RL8]
            state        <= S_BIST;
          end
          else
          begin
            rd_start <= 1'b1; // [RL2]
            rd_base  <= `RIS_BOOT_BASE;
            rd_cnt   <= `RIS_BOOT_WORDS;
            state    <= S_BOOT;
          end
        end
        S_BIST:
        begin
          if (i_bist_done && i_bist_pass)
          begin
            rd_start <= 1'b1;
            rd_base  <= `RIS_BOOT_BASE;
            rd_cnt   <= `RIS_BOOT_WORDS;
            state    <= S_BOOT;
          end
          else if (i_bist_done)
            state <= S_FAIL;
        end
        S_BOOT:
        begin
          if (wvld)
            sum <= sum + word; // [RL7]
          if (word_hit(wvld, widx, `RIS_BOOT_IP))
            boot_ip <= word; // [RL3]
          if (word_hit(wvld, widx, `RIS_BOOT_PROCESS_CONTROL_BLOCK))
            o_process_control_block_addr <= word; // [RL3]
          if (rd_done)
            state <= S_CHECK;
        end
        S_CHECK:
        begin
          // Bus confidence: words plus all-ones sum to zero
          if (chk == 32'h0)
          begin
            o_fail_n <= 1'b1; // [RL7]
            rd_start <= 1'b1;
            rd_base  <= o_process_control_block_addr;
            rd_cnt   <= `RIS_PROCESS_CONTROL_BLOCK_WORDS;
            state    <= S_PROCESS_CONTROL_BLOCK;
          end
          else
            state <= S_FAIL;
        end
        S_PROCESS_CONTROL_BLOCK:
        begin
          if (word_hit(wvld, widx, `RIS_PROCESS_CONTROL_BLOCK_CFG))
            o_config <= word; // [RL4]
          if (rd_done)
            state <= S_BRANCH;
        end
        S_BRANCH:
        begin
          o_branch    <= 1'b1; // [RL9]
          o_branch_ip <= boot_ip;
          state       <= S_RUN;
        end
        S_RUN:
        begin
          // Re-init skips the boot record and the tests
          if (i_reinit)
          begin
            o_process_control_block_addr <= i_reinit_process_control_block; // [RL6]
            boot_ip     <= i_reinit_ip;
            rd_start    <= 1'b1;
            rd_base     <= i_reinit_process_control_block;
            rd_cnt      <= `RIS_PROCESS_CONTROL_BLOCK_WORDS;
            state       <= S_PROCESS_CONTROL_BLOCK;
          end
        end
        S_FAIL:
        begin
          // Stuck until the reset pin is pulsed
          o_fail_n <= 1'b0;
        end
        default:
          state <= S_FAIL;
      endcase
    end
  end

  // ----------------------------------------
  // Cached system pointers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `RIS_NUM_PTRS; gi = gi + 1)
    begin : g_ptr
      localparam [31:0] KW = gi;
      localparam [3:0]  K  = KW[3:0];
      reg [31:0] ptr;
      always @(posedge i_sys_clk or posedge rst_a)
      begin
        if (rst_a)
          ptr <= 32'h0;
        else if ((state == S_PROCESS_CONTROL_BLOCK) && word_hit(wvld, widx, K))
          ptr <= word; // [RL5] [RL4]
      end
      assign o_sys_ptrs[gi*32 +: 32] = ptr;
    end
  endgenerate

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Hold levels match reset levels; core owns the
  // pins only when the bus is not lent out
  always @*
  begin
    next_ad      = 32'h0;
    next_ad_oe   = 1'b0;
    next_ale     = `RIS_ALE_IDLE;
    next_ads_n   = `RIS_ADS_IDLE;
    next_low     = 2'h0;
    next_low_oe  = 1'b0;
    next_be_n    = `RIS_BE_IDLE;
    next_whs     = 2'h0;
    next_whs_oe  = 1'b0;
    next_dc      = 1'b0;
    next_dc_oe   = 1'b0;
    next_wr      = `RIS_WR_IDLE;
    next_dtr     = `RIS_DTR_IDLE;
    next_den_n   = `RIS_DEN_IDLE;
    next_burst_last_n = `RIS_BURST_LAST_IDLE;
    if (!o_bus_hold_grant)
    begin
      next_ad      = i_core_ad;
      next_ad_oe   = i_core_ad_oe;
      next_ale     = i_core_ale;
      next_ads_n   = i_core_ads_n;
      next_low     = i_core_low_addr;
      next_low_oe  = i_core_low_addr_oe;
      next_be_n    = i_core_be_n;
      next_whs     = i_core_whs;
      next_whs_oe  = i_core_whs_oe;
      next_dc      = i_core_dc;
      next_dc_oe   = i_core_dc_oe;
      next_wr      = i_core_wr;
      next_dtr     = i_core_dtr;
      next_den_n   = i_core_den_n;
      next_burst_last_n = i_core_burst_last_n;
    end
  end

  always @(posedge i_sys_clk or posedge rst_a)
  begin
    if (rst_a)
    begin
      o_addr_data_bus         <= 32'h0;
      o_addr_data_bus_oe      <= 1'b0; // [RL17]
      o_addr_latch            <= `RIS_ALE_IDLE; // [RL17]
      o_address_strobe_n      <= `RIS_ADS_IDLE; // [RL18]
      o_low_address_bits      <= 2'h0;
      o_low_address_bits_oe   <= 1'b0; // [RL17]
      o_byte_lane_selects_n   <= `RIS_BE_IDLE; // [RL18]
      o_width_halt_status     <= 2'h0;
      o_width_halt_status_oe  <= 1'b0; // [RL17]
      o_data_code_status      <= 1'b0;
      o_data_code_status_oe   <= 1'b0; // [RL17]
      o_write_read            <= `RIS_WR_IDLE; // [RL18]
      o_transceiver_direction <= `RIS_DTR_IDLE; // [RL18]
      o_data_enable_strobe_n  <= `RIS_DEN_IDLE; // [RL18]
      o_burst_last_n          <= `RIS_BURST_LAST_IDLE; // [RL18] [RL1]
    end
    else
    begin
      o_addr_data_bus         <= next_ad;
      o_addr_data_bus_oe      <= next_ad_oe;
      o_addr_latch            <= next_ale;
      o_address_strobe_n      <= next_ads_n;
      o_low_address_bits      <= next_low;
      o_low_address_bits_oe   <= next_low_oe;
      o_byte_lane_selects_n   <= next_be_n;
      o_width_halt_status     <= next_whs;
      o_width_halt_status_oe  <= next_whs_oe;
      o_data_code_status      <= next_dc;
      o_data_code_status_oe   <= next_dc_oe;
      o_write_read            <= next_wr;
      o_transceiver_direction <= next_dtr;
      o_data_enable_strobe_n  <= next_den_n;
      o_burst_last_n          <= next_burst_last_n;
    end
  end

endmodule // ris_reset_init_seq

// ==== testbench/ris_mem_model.sv ====
`timescale 1ns/1ps
module ris_mem_model
(
  input  wire         i_sys_clk,
  input  wire         i_slow,
  input  wire         i_mem_req,
  input  wire  [31:0] i_mem_addr,
  output logic        o_mem_ack,
  output logic [31:0] o_mem_data,
  input  wire         i_bist_start,
  output logic        o_bist_done,
  output logic        o_bist_pass
);
  logic [31:0] boot [8];
  logic [31:0] boot_base = 32'h0;
  logic [7:0]  boot_ld   = 8'h0;

  task load(input logic [31:0] a, input logic [31:0] d);
    boot[a[4:2]]    = d;
    boot_base       = {a[31:5], 5'h0};
    boot_ld[a[4:2]] = 1'b1;
  endtask

  initial
  begin
    o_mem_ack   = 1'b0;
    o_mem_data  = 32'h0;
    o_bist_done = 1'b0;
    o_bist_pass = 1'b0;
  end

  // ----------------------------------------
  // Memory reads
  // ----------------------------------------
  // Unloaded places answer a pattern of their address
  always
  begin
    @(posedge i_sys_clk);
    #1;
    if (i_mem_req === 1'b1)
    begin
      if (i_slow)
      begin
        repeat (3) @(posedge i_sys_clk);
        #1;
      end
      // Request may be gone after a reset in the meantime
      if (i_mem_req === 1'b1)
      begin
        o_mem_ack  = 1'b1;
        if (boot_ld[i_mem_addr[4:2]] && {i_mem_addr[31:5], 5'h0} == boot_base)
          o_mem_data = boot[i_mem_addr[4:2]];
        else
          o_mem_data = i_mem_addr ^ 32'hA5A5_5A5A;
        @(posedge i_sys_clk);
        #1;
        o_mem_ack  = 1'b0;
        o_mem_data = ~o_mem_data;
      end
    end
  end

  // ----------------------------------------
  // Internal self test engine
  // ----------------------------------------
  always
  begin
    @(posedge i_sys_clk);
    #1;
    if (i_bist_start === 1'b1)
    begin
      repeat (6) @(posedge i_sys_clk);
      #1;
      o_bist_done = 1'b1;
      o_bist_pass = 1'b1;
      @(posedge i_sys_clk);
      #1;
      o_bist_done = 1'b0;
      o_bist_pass = 1'b0;
    end
  end
endmodule // ris_mem_model

// ==== testbench/ris_reset_init_seq_assertions.sv ====
`timescale 1ns/1ps
module ris_seq_checker
(
  input wire        i_sys_clk,
  input wire        i_rst,
  input wire        i_reset_n,
  input wire        i_bus_hold_req,
  input wire        i_reinit,
  input wire        i_mem_ack,
  input wire        o_mem_req,
  input wire [31:0] o_mem_addr,
  input wire        o_bist_start,
  input wire        o_addr_data_bus_oe,
  input wire        o_addr_latch,
  input wire        o_address_strobe_n,
  input wire        o_low_address_bits_oe,
  input wire [3:0]  o_byte_lane_selects_n,
  input wire        o_width_halt_status_oe,
  input wire        o_data_code_status_oe,
  input wire        o_write_read,
  input wire        o_transceiver_direction,
  input wire        o_data_enable_strobe_n,
  input wire        o_burst_last_n,
  input wire        o_bus_hold_grant,
  input wire        o_fail_n,
  input wire        o_in_reset,
  input wire        o_init_busy,
  input wire        o_branch
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // ----------------------------------------
  // Reset state
  // ----------------------------------------
  pins_float_a: assert property (
    o_in_reset |-> !o_addr_data_bus_oe && !o_low_address_bits_oe && !o_width_halt_status_oe
      && !o_data_code_status_oe && !o_addr_latch)
    else $error("bus pins driven in reset");
  pins_idle_a: assert property (
    o_in_reset |-> o_address_strobe_n && o_byte_lane_selects_n == 4'hF && !o_write_read
      && !o_transceiver_direction && o_data_enable_strobe_n && o_burst_last_n && !o_fail_n)
    else $error("strobe pins wrong in reset");
  reset_quiet_a: assert property (
    o_in_reset |-> !o_mem_req && !o_branch && !o_bist_start)
    else $error("activity in reset");
  async_entry_a: assert property (
    disable iff (i_rst) !i_reset_n |-> o_in_reset)
    else $error("reset pin low but not in reset");
  release_sync_a: assert property (
    $fell(o_in_reset) |-> $past(i_reset_n, 1) && $past(i_reset_n, 2))
    else $error("release not synchronised");
  no_self_reset_a: assert property (
    i_reset_n && $past(i_reset_n) && !$past(o_in_reset) |-> !o_in_reset)
    else $error("reset entered without reset pin");

  // ----------------------------------------
  // Initialization
  // ----------------------------------------
  init_start_a: assert property (
    $fell(o_in_reset) && !o_bus_hold_grant |-> ##[0:4] (o_bist_start || o_mem_req))
    else $error("initialization did not start");
  read_hold_a: assert property (
    disable iff (i_rst || !i_reset_n) o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
    else $error("read request dropped early");
  branch_end_a: assert property (
    o_branch |-> o_fail_n ##1 !o_init_busy)
    else $error("branch before tests passed");
  reinit_go_a: assert property (
    i_reinit && !o_init_busy && o_fail_n |-> ##[1:4] o_init_busy)
    else $error("reinit not taken");

  // ----------------------------------------
  // Bus hold
  // ----------------------------------------
  grant_reset_a: assert property (
    disable iff (i_rst) (o_in_reset && i_bus_hold_req) [*5] |-> o_bus_hold_grant)
    else $error("hold not granted in reset");
  grant_keep_a: assert property (
    disable iff (i_rst) o_bus_hold_grant && i_bus_hold_req |=> o_bus_hold_grant)
    else $error("grant dropped while requested");
  hold_pins_a: assert property (
    o_bus_hold_grant |=> o_address_strobe_n && !o_addr_data_bus_oe && o_data_enable_strobe_n)
    else $error("pins active during hold");

  c_branch: cover property (o_branch);
  c_grant_run: cover property (o_bus_hold_grant && !o_in_reset);
  c_reinit: cover property (i_reinit && !o_init_busy);
  c_fail: cover property (!o_fail_n && !o_init_busy && !o_in_reset);
endmodule // ris_seq_checker

bind ris_reset_init_seq ris_seq_checker u_seq_chk (.*);

// ==== testbench/ris_reset_init_seq_tb.sv ====
`timescale 1ns/1ps
`include "ris_defines.vh"
module ris_reset_init_seq_tb;
  logic          i_sys_clk = 0, i_rst = 1, i_reset_n = 0, i_self_test_select = 0;
  logic          i_bus_hold_req = 0, i_core_hold_ok = 0, i_reinit = 0, slow = 0, act = 0;
  logic [31:0]   i_reinit_process_control_block = 0, i_reinit_ip = 0;
  wire           o_mem_req, i_mem_ack, o_bist_start, i_bist_done, i_bist_pass;
  wire  [31:0]   o_mem_addr, i_mem_data, o_branch_ip, o_process_control_block_addr, o_config;
  wire           o_address_strobe_n, o_addr_data_bus_oe, o_bus_hold_grant, o_fail_n;
  wire           o_in_reset, o_init_busy, o_branch;
  wire  [3:0]    o_byte_lane_selects_n;
  wire  [127:0]  o_sys_ptrs;
  int            n_errors = 0, tests_run = 0, n_bist = 0;
  localparam     P1 = 32'h0000_1000, IP1 = 32'h0000_2000, P2 = 32'h0000_3000, IP2 = 32'h0000_4000;

  ris_reset_init_seq dut (.*, .i_core_ad({32{act}}), .i_core_ad_oe(act), .i_core_ale(act),
    .i_core_ads_n(~act), .i_core_low_addr({2{act}}), .i_core_low_addr_oe(act),
    .i_core_be_n({4{~act}}), .i_core_whs({2{act}}), .i_core_whs_oe(act), .i_core_dc(act),
    .i_core_dc_oe(act), .i_core_wr(act), .i_core_dtr(act), .i_core_den_n(~act),
    .i_core_burst_last_n(~act), .o_addr_data_bus(), .o_addr_latch(), .o_low_address_bits(),
    .o_low_address_bits_oe(), .o_width_halt_status(), .o_width_halt_status_oe(),
    .o_data_code_status(), .o_data_code_status_oe(), .o_write_read(),
    .o_transceiver_direction(), .o_data_enable_strobe_n(), .o_burst_last_n());

  ris_mem_model mem (.i_sys_clk(i_sys_clk), .i_slow(slow), .i_mem_req(o_mem_req),
    .i_mem_addr(o_mem_addr), .o_mem_ack(i_mem_ack), .o_mem_data(i_mem_data),
    .i_bist_start(o_bist_start), .o_bist_done(i_bist_done), .o_bist_pass(i_bist_pass));

  always #2.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (o_bist_start === 1'b1) n_bist++;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task check(input string what, input logic [127:0] exp, input logic [127:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  function logic [31:0] mw(input logic [31:0] a);
    return a ^ 32'hA5A5_5A5A;
  endfunction

  // Checksum word makes the eight words plus the constant sum to zero
  task boot_img(input logic [31:0] process_control_block, input logic [31:0] ip, input logic [31:0] bad);
    logic [31:0] w [8];
    logic [31:0] sum;
    sum = 32'h0;
    for (int k = 0; k < 7; k++) w[k] = 32'h1111_0000 * (k + 1);
    w[`RIS_BOOT_PROCESS_CONTROL_BLOCK] = process_control_block;
    w[`RIS_BOOT_IP] = ip;
    for (int k = 0; k < 7; k++) sum += w[k];
    w[7] = 32'h0 - sum - `RIS_CHK_CONST + bad;
    for (int k = 0; k < 8; k++) mem.load(`RIS_BOOT_BASE + 4 * k, w[k]);
  endtask

  task wait_branch;
    for (int i = 0; i < 400 && o_branch !== 1'b1; i++) cyc(1);
  endtask

  task warm_reset;
    i_reset_n = 1'b0;
    cyc(8);
    i_reset_n = 1'b1;
  endtask

  task check_process_control_block(input logic [31:0] p, input logic [31:0] ip);
    check("branch ip", ip, o_branch_ip);
    check("process_control_block addr", p, o_process_control_block_addr);
    check("config", mw(p + 4 * `RIS_PROCESS_CONTROL_BLOCK_CFG), o_config);
    check("ptrs", {mw(p + 12), mw(p + 8), mw(p + 4), mw(p)}, o_sys_ptrs);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset_state;
    act = 1'b1;
    cyc(4);
    check("ads_n in reset", 1, o_address_strobe_n);
    check("be_n in reset", 4'hF, o_byte_lane_selects_n);
    check("ad oe in reset", 0, o_addr_data_bus_oe);
    check("fail_n in reset", 0, o_fail_n);
    check("in reset flag", 1, o_in_reset);
    i_bus_hold_req = 1'b1;
    cyc(6);
    check("grant in reset", 1, o_bus_hold_grant);
    i_bus_hold_req = 1'b0;
    cyc(6);
    check("grant released", 0, o_bus_hold_grant);
    act = 1'b0;
  endtask

  task t_boot(input logic st);
    boot_img(P1, IP1, 0);
    i_self_test_select = st;
    n_bist = 0;
    warm_reset();
    wait_branch();
    check("branch", 1, o_branch);
    check_process_control_block(P1, IP1);
    check("fail_n after tests", 1, o_fail_n);
    check("bist runs", st, n_bist);
    act = 1'b1;
    cyc(2);
    check("ads_n follows core", 0, o_address_strobe_n);
    act = 1'b0;
  endtask

  task t_reinit;
    slow = 1'b1;
    i_reinit_process_control_block = P2;
    i_reinit_ip = IP2;
    i_reinit = 1'b1;
    cyc(1);
    i_reinit = 1'b0;
    wait_branch();
    check_process_control_block(P2, IP2);
    check("no reset on reinit", 0, o_in_reset);
    slow = 1'b0;
  endtask

  task t_warm_hold;
    i_core_hold_ok = 1'b1;
    i_bus_hold_req = 1'b1;
    cyc(6);
    check("grant in run", 1, o_bus_hold_grant);
    warm_reset();
    cyc(12);
    check("grant kept", 1, o_bus_hold_grant);
    check("no reads in hold", 0, o_mem_req);
    i_bus_hold_req = 1'b0;
    wait_branch();
    check_process_control_block(P1, IP1);
    check("grant dropped", 0, o_bus_hold_grant);
    i_core_hold_ok = 1'b0;
  endtask

  task t_bad_sum;
    boot_img(P1, IP1, 1);
    warm_reset();
    wait_branch();
    check("no branch", 0, o_branch);
    check("fail_n held", 0, o_fail_n);
    check("busy stops", 0, o_init_busy);
  endtask

  task test_done;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    cyc(8);
    i_rst = 1'b0;
    t_reset_state();
    t_boot(1'b0);
    t_boot(1'b1);
    t_reinit();
    t_warm_hold();
    t_bad_sum();
    test_done();
  end

  initial
  begin
    #100000;
    n_errors++;
    test_done();
  end
endmodule // ris_reset_init_seq_tb
